// file: common/fault_latch_pkg.sv
// Behaviour
// - three comparators per standard channel, all latched
// - any uninhibited channel comparator trip sets its latch
// - latch clears only on reset request or software clear, fault gone
// - negative reference comparator flags reversed polarity
// - settable comparator threshold loaded from software
// - four power pairs, one ratiometric latch each
// - each optical fault input has own latch
// - optical light healthy, dark latches fault
// - optical inputs: elbow, circulator, coupler protection
// - sequencer gates high voltage and rf drive
// - plc path: 16 commands in, 48 status out
// - duplex link 16 each way at 5 kHz
// - input link sends 32 channels at 5 kHz
// - inhibit masks only the settable comparator
// - six body comparators share one klystron latch
package fault_latch_pkg;
  // channel structure
  localparam int CHAN_N     = 16;
  localparam int CMP_PER_CH = 3;
  localparam int CMP_NEG    = 0;
  localparam int CMP_FIXED  = 1;
  localparam int CMP_SET    = 2;
  localparam int RATIO_N    = 4;
  localparam int OPT_N      = 9;
  localparam int OPT_ELBOW  = 0;
  localparam int OPT_CIRC   = 4;
  localparam int OPT_COUPLE = 8;
  localparam int KLY_N      = 4;
  localparam int BODY_SLOW  = 4;
  localparam int BODY_FAST  = 8;
  localparam int INH_N      = 4;
  localparam int DAC_W      = 12;
  localparam logic [DAC_W-1:0] DAC_RESET = 12'hfff;

  // synchronised input vector layout
  localparam int SY_CMP    = 0;
  localparam int SY_RATIO  = SY_CMP + CHAN_N * CMP_PER_CH;
  localparam int SY_OPT    = SY_RATIO + RATIO_N;
  localparam int SY_FIB_HV = SY_OPT + OPT_N;
  localparam int SY_FIB_RF = SY_FIB_HV + 1;
  localparam int SY_RST    = SY_FIB_RF + 1;
  localparam int SY_INH    = SY_RST + 1;
  localparam int SYNC_W    = SY_INH + INH_N;

  // latch vector layout
  localparam int LA_CHAN  = 0;
  localparam int LA_RATIO = LA_CHAN + CHAN_N;
  localparam int LA_OPT   = LA_RATIO + RATIO_N;
  localparam int LA_BODY  = LA_OPT + OPT_N;
  localparam int LATCH_W  = LA_BODY + KLY_N;

  // plc links
  localparam int CLK_HZ     = 250_000_000;
  localparam int PACKET_HZ  = 5_000;
  localparam int PACKET_CYC = CLK_HZ / PACKET_HZ;
  localparam int BIT_CYC    = 250;
  localparam int CMD_W      = 16;
  localparam int DUPLEX_W   = 16;
  localparam int INPUT_W    = 32;
  localparam int STATUS_W   = DUPLEX_W + INPUT_W;
  localparam int SPARE_W    = STATUS_W - LATCH_W - 4;
  localparam int CMD_HV     = 0;
  localparam int CMD_RF     = 1;

  // register map
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_LATCH_CH = 8'h08;
  localparam logic [7:0] A_LATCH_OT = 8'h0c;
  localparam logic [7:0] A_INH_EN   = 8'h10;
  localparam logic [7:0] A_PLC_CMD  = 8'h14;
  localparam logic [7:0] A_SPARE    = 8'h18;
  localparam logic [7:0] A_IRQ_STAT = 8'h1c;
  localparam logic [7:0] A_IRQ_MASK = 8'h20;
  localparam logic [7:0] A_DAC_BASE = 8'h40;
  localparam int CTRL_ARM   = 0;
  localparam int CTRL_CLEAR = 1;

  // interrupt status bits
  localparam int IRQ_CHAN  = 0;
  localparam int IRQ_RATIO = 1;
  localparam int IRQ_OPT   = 2;
  localparam int IRQ_BODY  = 3;
  localparam int IRQ_TRIP  = 4;
  localparam int IRQ_CMD   = 5;
  localparam int IRQ_W     = 6;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_HV   = 2'b01,
    SEQ_RF   = 2'b11,
    SEQ_TRIP = 2'b10
  } seq_state_t;
endpackage : fault_latch_pkg

// file: common/latch_bank_if.sv
`timescale 1ns/1ns
interface latch_bank_if;
  logic [fault_latch_pkg::SYNC_W-1:0]  raw;
  logic [fault_latch_pkg::SYNC_W-1:0]  sync;
  logic [fault_latch_pkg::LATCH_W-1:0] set;
  logic [fault_latch_pkg::LATCH_W-1:0] latch;
  logic                                clear;
  modport bank (input raw, input set, input clear, output sync, output latch);
  modport core (output raw, output set, output clear, input sync, input latch);
endinterface : latch_bank_if

// file: common/link_word_if.sv
`timescale 1ns/1ns
interface link_word_if #(
  parameter int TW = 16,
  parameter int RW = 16
);
  logic [TW-1:0] tx_word;
  logic [RW-1:0] rx_word;
  logic          rx_valid;
  modport link (input tx_word, output rx_word, output rx_valid);
  modport user (output tx_word, input rx_word, input rx_valid);
endinterface : link_word_if

// file: hw/fault_latch_bank.sv
`timescale 1ns/1ns
module fault_latch_bank (
  // clock and reset
  input wire logic    ref_clk,
  input wire logic    rst_n,
  // core side
  latch_bank_if.bank  bus
);
  logic [fault_latch_pkg::SYNC_W-1:0]  meta_r;
  logic [fault_latch_pkg::SYNC_W-1:0]  sync_r;
  logic [fault_latch_pkg::LATCH_W-1:0] latch_r;
  logic [fault_latch_pkg::LATCH_W-1:0] latch_nxt;

  // set wins; clear only where the fault is gone
  always_comb begin
    latch_nxt = (latch_r & ~({fault_latch_pkg::LATCH_W{bus.clear}} & ~bus.set)) | bus.set;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r  <= '0;
      sync_r  <= '0;
      latch_r <= '0;
    end else begin
      meta_r  <= bus.raw;
      sync_r  <= meta_r;
      latch_r <= latch_nxt;
    end
  end

  assign bus.sync  = sync_r;
  assign bus.latch = latch_r;
endmodule : fault_latch_bank

// file: hw/mux_link.sv
`timescale 1ns/1ns
module mux_link #(
  parameter int TW         = 16,
  parameter int RW         = 16,
  parameter int HAS_RX     = 1,
  parameter int PACKET_CYC = 50000,
  parameter int BIT_CYC    = 250
)(
  // clock and reset
  input wire logic  ref_clk,
  input wire logic  rst_n,
  // user side
  link_word_if.link w,
  // fibre side, idle high
  input wire logic  line_in,
  output logic      line_out
);
  localparam int PW = $clog2(PACKET_CYC);
  localparam int BW = $clog2(BIT_CYC);
  localparam int FW = TW + 2;
  localparam int NW = $clog2(FW + 1);

  logic [PW-1:0] pkt_r, pkt_nxt;
  logic [BW-1:0] tbit_r, tbit_nxt;
  logic [NW-1:0] tleft_r, tleft_nxt;
  logic [FW-1:0] tsh_r, tsh_nxt;
  logic          line_nxt;

  // one frame per packet period: start 0, data lsb first, stop 1
  always_comb begin
    pkt_nxt   = (pkt_r == PW'(PACKET_CYC - 1)) ? '0 : pkt_r + 1'b1;
    tbit_nxt  = tbit_r;
    tleft_nxt = tleft_r;
    tsh_nxt   = tsh_r;
    line_nxt  = line_out;
    if (pkt_r == '0) begin
      tsh_nxt   = {1'b1, w.tx_word, 1'b0};
      tleft_nxt = NW'(FW);
      tbit_nxt  = '0;
    end else if (tleft_r != '0) begin
      if (tbit_r == '0) begin
        line_nxt  = tsh_r[0];
        tsh_nxt   = {1'b1, tsh_r[FW-1:1]};
        tleft_nxt = tleft_r - 1'b1;
        tbit_nxt  = BW'(BIT_CYC - 1);
      end else begin
        tbit_nxt = tbit_r - 1'b1;
      end
    end else begin
      line_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pkt_r    <= '0;
      tbit_r   <= '0;
      tleft_r  <= '0;
      tsh_r    <= '1;
      line_out <= 1'b1;
    end else begin
      pkt_r    <= pkt_nxt;
      tbit_r   <= tbit_nxt;
      tleft_r  <= tleft_nxt;
      tsh_r    <= tsh_nxt;
      line_out <= line_nxt;
    end
  end

  if (HAS_RX != 0) begin : g_rx
    localparam int IW = $clog2(RW + 2);
    logic          meta_r, sync_r, busy_r, busy_nxt, valid_r, valid_nxt;
    logic [BW-1:0] rcnt_r, rcnt_nxt;
    logic [IW-1:0] ridx_r, ridx_nxt;
    logic [RW-1:0] rsh_r, rsh_nxt, word_r, word_nxt;

    // mid-bit sampling; a frame with a bad start or stop is dropped
    always_comb begin
      busy_nxt  = busy_r;
      rcnt_nxt  = rcnt_r;
      ridx_nxt  = ridx_r;
      rsh_nxt   = rsh_r;
      word_nxt  = word_r;
      valid_nxt = 1'b0;
      if (!busy_r) begin
        if (!sync_r) begin
          busy_nxt = 1'b1;
          rcnt_nxt = BW'(BIT_CYC / 2);
          ridx_nxt = '0;
        end
      end else if (rcnt_r != '0) begin
        rcnt_nxt = rcnt_r - 1'b1;
      end else begin
        rcnt_nxt = BW'(BIT_CYC - 1);
        if (ridx_r == '0) begin
          if (sync_r) busy_nxt = 1'b0;
          else ridx_nxt = ridx_r + 1'b1;
        end else if (ridx_r <= IW'(RW)) begin
          rsh_nxt  = {sync_r, rsh_r[RW-1:1]};
          ridx_nxt = ridx_r + 1'b1;
        end else begin
          busy_nxt = 1'b0;
          if (sync_r) begin
            word_nxt  = rsh_r;
            valid_nxt = 1'b1;
          end
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        meta_r  <= 1'b1;
        sync_r  <= 1'b1;
        busy_r  <= 1'b0;
        valid_r <= 1'b0;
        rcnt_r  <= '0;
        ridx_r  <= '0;
        rsh_r   <= '0;
        word_r  <= '0;
      end else begin
        meta_r  <= line_in;
        sync_r  <= meta_r;
        busy_r  <= busy_nxt;
        valid_r <= valid_nxt;
        rcnt_r  <= rcnt_nxt;
        ridx_r  <= ridx_nxt;
        rsh_r   <= rsh_nxt;
        word_r  <= word_nxt;
      end
    end
    assign w.rx_word  = word_r;
    assign w.rx_valid = valid_r;
  end else begin : g_no_rx
    assign w.rx_word  = '0;
    assign w.rx_valid = 1'b0;
  end
endmodule : mux_link

// file: hw/fault_latch_interlock.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
module fault_latch_interlock #(
  parameter int PACKET_CYC = fault_latch_pkg::PACKET_CYC,
  parameter int BIT_CYC    = fault_latch_pkg::BIT_CYC
)(
  // clock and reset
  input wire logic                                                       ref_clk,
  input wire logic                                                       rst_n,
  // apb slave
  input wire logic [7:0]                                                 paddr,
  input wire logic                                                       psel,
  input wire logic                                                       penable,
  input wire logic                                                       pwrite,
  input wire logic [31:0]                                                pwdata,
  output logic [31:0]                                                    prdata,
  output logic                                                           pready,
  output logic                                                           pslverr,
  // comparator pins, channel c bits 3c..3c+2
  input wire logic [fault_latch_pkg::CHAN_N*fault_latch_pkg::CMP_PER_CH-1:0] cmp_trip,
  input wire logic [fault_latch_pkg::RATIO_N-1:0]                        ratio_trip,
  // optical fault receivers, high while lit
  input wire logic [fault_latch_pkg::OPT_N-1:0]                          opt_light,
  // fast fibre control and reset
  input wire logic                                                       fibre_hv_req,
  input wire logic                                                       fibre_rf_req,
  input wire logic                                                       fault_reset_req,
  input wire logic [fault_latch_pkg::INH_N-1:0]                          inhibit_win,
  // threshold dacs
  output logic [fault_latch_pkg::CHAN_N-1:0][fault_latch_pkg::DAC_W-1:0] dac_level,
  // plc links
  input wire logic                                                       duplex_rx,
  output logic                                                           duplex_tx,
  output logic                                                           input_link_tx,
  // drive enables and interrupt
  output logic                                                           high_voltage_on,
  output logic                                                           rf_drive_on,
  output logic                                                           fault_irq
);
  latch_bank_if bank_bus ();
  link_word_if #(.TW(fault_latch_pkg::DUPLEX_W), .RW(fault_latch_pkg::CMD_W)) duplex_bus ();
  link_word_if #(.TW(fault_latch_pkg::INPUT_W), .RW(1)) input_bus ();

  fault_latch_bank u_bank (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (bank_bus)
  );

  mux_link #(
    .TW         (fault_latch_pkg::DUPLEX_W),
    .RW         (fault_latch_pkg::CMD_W),
    .HAS_RX     (1),
    .PACKET_CYC (PACKET_CYC),
    .BIT_CYC    (BIT_CYC)
  ) u_duplex (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .w        (duplex_bus),
    .line_in  (duplex_rx),
    .line_out (duplex_tx)
  );

  mux_link #(
    .TW         (fault_latch_pkg::INPUT_W),
    .RW         (1),
    .HAS_RX     (0),
    .PACKET_CYC (PACKET_CYC),
    .BIT_CYC    (BIT_CYC)
  ) u_input (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .w        (input_bus),
    .line_in  (1'b1),
    .line_out (input_link_tx)
  );

  logic                                    arm_r, arm_nxt;
  logic                                    clr_r, clr_nxt;
  logic [fault_latch_pkg::CHAN_N-1:0]      inh_en_r, inh_en_nxt;
  logic [fault_latch_pkg::SPARE_W-1:0]     spare_r, spare_nxt;
  logic [fault_latch_pkg::CMD_W-1:0]       cmd_r, cmd_nxt;
  logic [fault_latch_pkg::IRQ_W-1:0]       mask_r, mask_nxt, stat_r, stat_nxt, ev;
  logic [fault_latch_pkg::LATCH_W-1:0]     prev_r, latch, rise;
  logic [fault_latch_pkg::CHAN_N-1:0][fault_latch_pkg::DAC_W-1:0] dac_nxt;
  logic [31:0]                             prdata_nxt;
  logic                                    pready_nxt, pslverr_nxt, irq_nxt;
  logic [fault_latch_pkg::CHAN_N-1:0]      chan_fault;
  logic [fault_latch_pkg::KLY_N-1:0]       body_fault;
  logic                                    inh_any, any_latch, hv_ok, rf_ok, wr_en, rd_en;
  logic                                    hv_nxt, rf_nxt;
  fault_latch_pkg::seq_state_t             state_r, state_nxt;

  // pin bank; optical darkness becomes a fault level
  assign bank_bus.raw = {inhibit_win, fault_reset_req, fibre_rf_req, fibre_hv_req,
                         ~opt_light, ratio_trip, cmp_trip};
  assign inh_any = |bank_bus.sync[fault_latch_pkg::SY_INH +: fault_latch_pkg::INH_N];

  for (genvar c = 0; c < fault_latch_pkg::CHAN_N; c++) begin : g_chan
    localparam int B = fault_latch_pkg::SY_CMP + c * fault_latch_pkg::CMP_PER_CH;
    assign chan_fault[c] = bank_bus.sync[B + fault_latch_pkg::CMP_NEG]
                         | bank_bus.sync[B + fault_latch_pkg::CMP_FIXED]
                         | (bank_bus.sync[B + fault_latch_pkg::CMP_SET]
                            & ~(inh_en_r[c] & inh_any));
  end

  for (genvar k = 0; k < fault_latch_pkg::KLY_N; k++) begin : g_body
    assign body_fault[k] = chan_fault[fault_latch_pkg::BODY_SLOW + k]
                         | chan_fault[fault_latch_pkg::BODY_FAST + k];
  end

  // elbow 0-3, circulator 4-7, coupler protection 8 in the optical field
  assign bank_bus.set = {body_fault,
                         bank_bus.sync[fault_latch_pkg::SY_OPT +: fault_latch_pkg::OPT_N],
                         bank_bus.sync[fault_latch_pkg::SY_RATIO +: fault_latch_pkg::RATIO_N],
                         chan_fault};
  assign bank_bus.clear = bank_bus.sync[fault_latch_pkg::SY_RST] | clr_r;

  assign latch     = bank_bus.latch;
  assign any_latch = |latch;
  assign rise      = latch & ~prev_r;

  // status toward the plc: 16 on the duplex link, 32 on the input link
  assign {input_bus.tx_word, duplex_bus.tx_word} =
         {spare_r, state_r, rf_drive_on, high_voltage_on, latch};

  // sequencer
  assign hv_ok = arm_r & cmd_r[fault_latch_pkg::CMD_HV] & bank_bus.sync[fault_latch_pkg::SY_FIB_HV];
  assign rf_ok = cmd_r[fault_latch_pkg::CMD_RF] & bank_bus.sync[fault_latch_pkg::SY_FIB_RF];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fault_latch_pkg::SEQ_IDLE: begin
        if (any_latch) state_nxt = fault_latch_pkg::SEQ_TRIP;
        else if (hv_ok) state_nxt = fault_latch_pkg::SEQ_HV;
      end
      fault_latch_pkg::SEQ_HV: begin
        if (any_latch) state_nxt = fault_latch_pkg::SEQ_TRIP;
        else if (!hv_ok) state_nxt = fault_latch_pkg::SEQ_IDLE;
        else if (rf_ok) state_nxt = fault_latch_pkg::SEQ_RF;
      end
      fault_latch_pkg::SEQ_RF: begin
        if (any_latch) state_nxt = fault_latch_pkg::SEQ_TRIP;
        else if (!hv_ok) state_nxt = fault_latch_pkg::SEQ_IDLE;
        else if (!rf_ok) state_nxt = fault_latch_pkg::SEQ_HV;
      end
      fault_latch_pkg::SEQ_TRIP: begin
        if (!any_latch) state_nxt = fault_latch_pkg::SEQ_IDLE;
      end
    endcase
    hv_nxt = (state_nxt == fault_latch_pkg::SEQ_HV) | (state_nxt == fault_latch_pkg::SEQ_RF);
    rf_nxt = (state_nxt == fault_latch_pkg::SEQ_RF);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r         <= fault_latch_pkg::SEQ_IDLE;
      high_voltage_on <= 1'b0;
      rf_drive_on     <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      high_voltage_on <= hv_nxt;
      rf_drive_on     <= rf_nxt;
    end
  end

  // apb: answer in the first access cycle; writes and read-clear land there
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & pready & ~pwrite;

  always_comb begin
    arm_nxt     = arm_r;
    clr_nxt     = 1'b0;
    inh_en_nxt  = inh_en_r;
    spare_nxt   = spare_r;
    mask_nxt    = mask_r;
    dac_nxt     = dac_level;
    cmd_nxt     = duplex_bus.rx_valid ? duplex_bus.rx_word : cmd_r;
    pready_nxt  = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = '0;
    ev = '0;
    ev[fault_latch_pkg::IRQ_CHAN]  = |rise[fault_latch_pkg::LA_CHAN +: fault_latch_pkg::CHAN_N];
    ev[fault_latch_pkg::IRQ_RATIO] = |rise[fault_latch_pkg::LA_RATIO +: fault_latch_pkg::RATIO_N];
    ev[fault_latch_pkg::IRQ_OPT]   = |rise[fault_latch_pkg::LA_OPT +: fault_latch_pkg::OPT_N];
    ev[fault_latch_pkg::IRQ_BODY]  = |rise[fault_latch_pkg::LA_BODY +: fault_latch_pkg::KLY_N];
    ev[fault_latch_pkg::IRQ_TRIP]  = (state_nxt == fault_latch_pkg::SEQ_TRIP)
                                   & (state_r != fault_latch_pkg::SEQ_TRIP);
    ev[fault_latch_pkg::IRQ_CMD]   = duplex_bus.rx_valid;
    stat_nxt = stat_r;
    if (rd_en && {paddr[7:2], 2'b00} == fault_latch_pkg::A_IRQ_STAT) stat_nxt = '0;
    stat_nxt = stat_nxt | ev;
    if (psel && !penable) begin
      if (paddr[7:6] == fault_latch_pkg::A_DAC_BASE[7:6]) begin
        prdata_nxt = 32'(dac_level[paddr[5:2]]);
      end else begin
        unique case ({paddr[7:2], 2'b00})
          fault_latch_pkg::A_CTRL:     prdata_nxt = 32'(arm_r);
          fault_latch_pkg::A_STATUS:   prdata_nxt = 32'({any_latch, rf_drive_on, high_voltage_on, state_r});
          fault_latch_pkg::A_LATCH_CH: prdata_nxt = 32'(latch[fault_latch_pkg::LA_CHAN +: fault_latch_pkg::CHAN_N]);
          fault_latch_pkg::A_LATCH_OT: prdata_nxt = 32'(latch[fault_latch_pkg::LATCH_W-1:fault_latch_pkg::LA_RATIO]);
          fault_latch_pkg::A_INH_EN:   prdata_nxt = 32'(inh_en_r);
          fault_latch_pkg::A_PLC_CMD:  prdata_nxt = 32'(cmd_r);
          fault_latch_pkg::A_SPARE:    prdata_nxt = 32'(spare_r);
          fault_latch_pkg::A_IRQ_STAT: prdata_nxt = 32'(stat_r);
          fault_latch_pkg::A_IRQ_MASK: prdata_nxt = 32'(mask_r);
          default:                     pslverr_nxt = 1'b1;
        endcase
      end
    end
    if (wr_en && !pslverr) begin
      if (paddr[7:6] == fault_latch_pkg::A_DAC_BASE[7:6]) begin
        dac_nxt[paddr[5:2]] = pwdata[fault_latch_pkg::DAC_W-1:0];
      end else begin
        unique case ({paddr[7:2], 2'b00})
          fault_latch_pkg::A_CTRL: begin
            arm_nxt = pwdata[fault_latch_pkg::CTRL_ARM];
            clr_nxt = pwdata[fault_latch_pkg::CTRL_CLEAR];
          end
          fault_latch_pkg::A_INH_EN:   inh_en_nxt = pwdata[fault_latch_pkg::CHAN_N-1:0];
          fault_latch_pkg::A_SPARE:    spare_nxt  = pwdata[fault_latch_pkg::SPARE_W-1:0];
          fault_latch_pkg::A_IRQ_MASK: mask_nxt   = pwdata[fault_latch_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arm_r     <= 1'b0;
      clr_r     <= 1'b0;
      inh_en_r  <= '0;
      spare_r   <= '0;
      cmd_r     <= '0;
      mask_r    <= '0;
      stat_r    <= '0;
      prev_r    <= '0;
      dac_level <= {fault_latch_pkg::CHAN_N{fault_latch_pkg::DAC_RESET}};
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      fault_irq <= 1'b0;
    end else begin
      arm_r     <= arm_nxt;
      clr_r     <= clr_nxt;
      inh_en_r  <= inh_en_nxt;
      spare_r   <= spare_nxt;
      cmd_r     <= cmd_nxt;
      mask_r    <= mask_nxt;
      stat_r    <= stat_nxt;
      prev_r    <= latch;
      dac_level <= dac_nxt;
      prdata    <= prdata_nxt;
      pready    <= pready_nxt;
      pslverr   <= pslverr_nxt;
      fault_irq <= irq_nxt;
    end
  end
endmodule : fault_latch_interlock

// file: dv/plc_model.sv
`timescale 1ns/1ns
module plc_model #(
  parameter int BIT_CYC = 4
)(
  // clock
  input wire logic        ref_clk,
  // command frame request
  input wire logic        send,
  input wire logic [15:0] cmd,
  // fibre line, idles high
  output logic            line
);
  logic [17:0] frame_r = '1;
  int          cnt_r   = 0;
  always_ff @(posedge ref_clk) begin
    if (send) begin
      frame_r <= {1'b1, cmd, 1'b0};
      cnt_r   <= 0;
    end else if (cnt_r == BIT_CYC - 1) begin
      frame_r <= {1'b1, frame_r[17:1]};
      cnt_r   <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  assign line = frame_r[0];
endmodule : plc_model

// file: dv/interlock_check_properties.sv
`timescale 1ns/1ns
module interlock_check (
  // clock, reset and apb
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // faults and requests
  input wire logic [fault_latch_pkg::RATIO_N-1:0] ratio_trip,
  input wire logic [fault_latch_pkg::OPT_N-1:0]   opt_light,
  input wire logic fibre_hv_req,
  input wire logic fault_reset_req,
  // outputs
  input wire logic duplex_tx,
  input wire logic input_link_tx,
  input wire logic high_voltage_on,
  input wire logic rf_drive_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready too long");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ratio_trip_off_a: assert property ((|ratio_trip) [*6] |-> !high_voltage_on && !rf_drive_on)
    else $error("ratio fault left drive on");
  dark_fibre_off_a: assert property ((opt_light != '1) [*6] |-> !high_voltage_on)
    else $error("dark fibre left high_voltage_on");
  latch_holds_a: assert property ((|ratio_trip) [*6] ##1 (!fault_reset_req && !psel) [*8] |-> !high_voltage_on)
    else $error("latch released without reset");
  hv_needs_fibre_a: assert property ((!fibre_hv_req) [*6] |-> !high_voltage_on)
    else $error("high_voltage_on without fibre request");
  link_idle_a: assert property ($rose(rst_n) |-> duplex_tx && input_link_tx)
    else $error("link not idle after reset");
  cover property (rf_drive_on);
  cover property (pslverr);
  cover property ($fell(high_voltage_on));
endmodule : interlock_check

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int PC = 200;
  localparam int BC = 4;
  logic              ref_clk, pready, pslverr, duplex_rx, duplex_tx, input_link_tx;
  logic              high_voltage_on, rf_drive_on, fault_irq, e;
  logic              rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0;
  logic              fibre_hv_req = 1'b0, fibre_rf_req = 1'b0, fault_reset_req = 1'b0;
  logic [7:0]        paddr = 8'h0;
  logic [31:0]       pwdata = 32'h0, prdata, q;
  logic [47:0]       cmp_trip = 48'h0;
  logic [3:0]        ratio_trip = 4'h0, inhibit_win = 4'h0;
  logic [8:0]        opt_light = 9'h1ff;
  logic [15:0][11:0] dac_level;
  int                miscompares = 0, check_count = 0;
  fault_latch_interlock #(.PACKET_CYC(PC), .BIT_CYC(BC)) fault_latch_interlock_inst (.*);
  plc_model #(.BIT_CYC(BC)) plc_model_inst (.ref_clk, .send, .cmd(16'h3), .line(duplex_rx));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic timeout_end();
    miscompares++;
    stop_test();
  endtask : timeout_end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic chk_b(input string nm, input logic x, input logic g);
    chk(nm, 32'(x), 32'(g));
  endtask : chk_b
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n = 0;
    tick(1);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeout_end();
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0, q, e);
    chk($sformatf("reg %h", a), x, q);
  endtask : rchk
  task automatic rx_frame(output logic [31:0] w, v);
    int n = 0;
    int h = 0;
    w = 32'h0;
    while ((h < 20 * BC || duplex_tx !== 1'b0) && n < 2000) begin
      tick(1);
      h = (duplex_tx === 1'b1) ? h + 1 : (h < 20 * BC ? 0 : h);
      n++;
    end
    if (n >= 2000) timeout_end();
    tick(BC / 2);
    for (int i = 0; i < 32; i++) begin
      tick(BC);
      v[i] = input_link_tx;
      if (i < 16) w[i] = duplex_tx;
    end
  endtask : rx_frame
  task automatic t_regs();
    rchk(8'h40, 32'hfff);
    apb(8'h4c, 1'b1, 32'h123, q, e);
    rchk(8'h4c, 32'h123);
    chk("dac3", 32'h123, 32'(dac_level[3]));
    apb(8'h30, 1'b0, 32'h0, q, e);
    chk_b("slverr", 1'b1, e);
    chk("unmapped", 32'h0, q);
  endtask : t_regs
  task automatic t_seq();
    int n = 0;
    apb(8'h20, 1'b1, 32'h3f, q, e);
    apb(8'h00, 1'b1, 32'h1, q, e);
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
    while (fault_irq !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) timeout_end();
    rchk(8'h1c, 32'h20);
    rchk(8'h14, 32'h3);
    fibre_hv_req <= 1'b1;
    fibre_rf_req <= 1'b1;
    tick(8);
    chk_b("irq", 1'b0, fault_irq);
    rchk(8'h04, 32'hf);
    chk_b("rf", 1'b1, rf_drive_on);
  endtask : t_seq
  task automatic t_fault(input logic [47:0] c, input logic [3:0] r, input logic [8:0] d,
                         input logic [7:0] a, input logic [31:0] x);
    cmp_trip <= c;
    ratio_trip <= r;
    opt_light <= ~d;
    tick(7);
    chk_b("hv", 1'b0, high_voltage_on);
    chk_b("irq", 1'b1, fault_irq);
    rchk(a, x);
    apb(8'h1c, 1'b0, 32'h0, q, e);
    fault_reset_req <= 1'b1;
    tick(4);
    fault_reset_req <= 1'b0;
    tick(4);
    chk_b("irq", 1'b0, fault_irq);
    rchk(a, x);
    cmp_trip <= 48'h0;
    ratio_trip <= 4'h0;
    opt_light <= 9'h1ff;
    tick(10);
    rchk(a, x);
    apb(8'h00, 1'b1, 32'h3, q, e);
    tick(8);
    rchk(a, 32'h0);
    chk_b("hv", 1'b1, high_voltage_on);
  endtask : t_fault
  task automatic t_inhibit();
    logic [31:0] w, v;
    apb(8'h10, 1'b1, 32'h4, q, e);
    apb(8'h20, 1'b1, 32'h0, q, e);
    inhibit_win <= 4'h8;
    cmp_trip <= 48'h100;
    tick(8);
    rchk(8'h08, 32'h0);
    chk_b("hv", 1'b1, high_voltage_on);
    cmp_trip <= 48'h140;
    tick(8);
    rchk(8'h08, 32'h4);
    chk_b("irq", 1'b0, fault_irq);
    rx_frame(w, v);
    chk("duplex", 32'h4, w);
    chk("input", 32'h0010_0000, v);
    rchk(8'h1c, 32'h11);
    cmp_trip <= 48'h0;
    fault_reset_req <= 1'b1;
    tick(4);
    fault_reset_req <= 1'b0;
    tick(2);
    rchk(8'h08, 32'h0);
  endtask : t_inhibit
  initial begin
    tick(20);
    rst_n <= 1'b1;
    t_regs();
    t_seq();
    t_fault(48'h1, 4'h0, 9'h0, 8'h08, 32'h1);
    t_fault(48'h1_0000, 4'h0, 9'h0, 8'h08, 32'h20);
    t_fault(48'h4000, 4'h0, 9'h0, 8'h0c, 32'h2000);
    t_fault(48'h0, 4'h4, 9'h0, 8'h0c, 32'h4);
    t_fault(48'h0, 4'h0, 9'h2, 8'h0c, 32'h20);
    t_fault(48'h0, 4'h0, 9'h10, 8'h0c, 32'h100);
    t_fault(48'h0, 4'h0, 9'h100, 8'h0c, 32'h1000);
    t_inhibit();
    stop_test();
  end
endmodule : testbench
bind fault_latch_interlock interlock_check interlock_check_inst (.*);
